// ===== src/wts_pkg.sv
// Constants, register map and field layout of the week timer sub-second and
// sub-week control block.
// Assumes a single clock domain and a plain strobe register port.
//
// Notes on behaviour
// - Four-bit rate select; zero turns every sub-second event off.
// - Rate value n from 1 to 15 gives events at 2 to the n hertz.
// - Bits 9:7 of sub-week control pick the sub-week counter clock source.
// - Bit 6 clear reloads the counter on expiry; bit 6 set does not.
// - Gate bit 5 set lets the wake output rise only while mains is present.
// - Read-only bit 4 returns the live mains presence level.
// - Long alarm flag sets while week count reaches compare and wake output enabled.
// - Writing one clears a wake flag; writing zero leaves it alone.
// - The long alarm part of the wake output ignores its flag.
// - Short alarm flag sets when the counter expires stepping from one (to zero or to reload), if enabled.
// - The short alarm wake stays until software clears its flag with a one.
// - Wake output enable clear holds the wake output low.
// - Nonzero reload write loads the counter; zero write stops it.
package wts_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_RATE_SELECT = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SUBWEEK_CTRL = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SUBWEEK_COUNT = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h44;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_WAKE_EN_BIT = 6;
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 4;
    localparam int SW_FLAG_SHORT_BIT = 0;
    localparam int SW_FLAG_LONG_BIT = 1;
    localparam int SW_MAINS_LEVEL_BIT = 4;
    localparam int SW_GATE_BIT = 5;
    localparam int SW_NO_RELOAD_BIT = 6;
    localparam int SW_SRC_LSB = 7;
    localparam int SW_SRC_W = 3;
    localparam int SWC_LOAD_LSB = 0;
    localparam int SWC_STATUS_LSB = 16;
    localparam int SWC_W = 9;
    localparam int IRQ_SUBSEC_BIT = 0;
    localparam int IRQ_SHORT_BIT = 1;
    localparam int IRQ_LONG_BIT = 2;
    localparam int IRQ_W = 3;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic RST_RUN = 1'b1;
    localparam logic RST_WAKE_EN = 1'b0;
    localparam logic [RATE_W-1:0] RST_RATE = 4'h0;
    localparam logic [SW_SRC_W-1:0] RST_SRC = 3'h0;
    localparam logic [SWC_W-1:0] RST_SWC = 9'h000;
    localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int REF_HZ = 32768;
    localparam int DIV_W = 15;

endpackage

// ===== src/wts_tick_if.sv
// Carrier between the sub-second tick generator and the control block.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface wts_tick_if;
    logic tick32;
    logic run;
    logic [wts_pkg::RATE_W-1:0] rate;
    logic evt;
    logic [wts_pkg::DIV_W-1:0] div;
    modport gen (input tick32, input run, input rate, output evt, output div);
    modport ctl (output tick32, output run, output rate, input evt, input div);
endinterface

// ===== src/wts_subsec.sv
// Fifteen-bit divider of the 32 kHz reference and the sub-second event tap.
// Assumes tick32 is a one-cycle pulse per reference period on mclk.
`timescale 1ns/1ps
module wts_subsec #(
    parameter int DIV_BITS = wts_pkg::DIV_W
) (
    input wire logic mclk,
    input wire logic rst,
    wts_tick_if.gen tk
);
    import wts_pkg::*;

    typedef struct packed {
        logic [DIV_BITS-1:0] div;
        logic evt;
    } wts_sub_state_s;

    wts_sub_state_s st_reg;
    wts_sub_state_s st_next;
    logic [DIV_BITS-1:0] tap_mask;

    // ==========================================================
    // Checks
    // ==========================================================
    if (DIV_BITS != DIV_W) begin : g_bad_width
        $error("Divider width must match the fifteen rate codes.");
    end

    // ==========================================================
    // Divider and tap
    // ==========================================================
    always_comb begin
        st_next = st_reg;
        // tap per rate: period is 2 to the (15 - n) reference ticks.
        tap_mask = (DIV_BITS'(1) << (DIV_BITS - int'(tk.rate))) - DIV_BITS'(1);
        st_next.evt = 1'b0;
        if (!tk.run) begin
            // Divider is held clear while the timer is stopped.
            st_next.div = '0;
        end else if (tk.tick32) begin
            st_next.div = st_reg.div + DIV_BITS'(1);
            // divider tap event, one cycle per period.
            if (tk.rate != '0 && (st_reg.div & tap_mask) == tap_mask) begin
                st_next.evt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tk.evt = st_reg.evt;
    assign tk.div = st_reg.div;

endmodule

// ===== src/wts_ctrl.sv
// Sub-second rate select, sub-week control and status, wake output and
// event interrupt of the battery-domain week timer.
// Assumes week_compare_hit and the tick sources come from logic on mclk;
// ref_32k_pin and mains_presence_input are asynchronous pins.
`timescale 1ns/1ps
module wts_ctrl #(
    parameter int SRC_COUNT = 8,
    parameter int SRC_SEL_W = wts_pkg::SW_SRC_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [wts_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ref_32k_pin,
    input wire logic mains_presence_input,
    input wire logic week_compare_hit,
    input wire logic [SRC_COUNT-1:0] short_alarm_clock_select_src,
    output logic wake_event,
    output logic subsecond_event,
    output logic irq
);
    import wts_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic ref_meta;
        logic ref_sync;
        logic ref_prev;
        logic pres_meta;
        logic pres_sync;
        logic long_alarm_run;
        logic wake_output_enable;
        logic [RATE_W-1:0] subsecond_rate_select;
        logic [SRC_SEL_W-1:0] short_alarm_clock_select;
        logic no_reload;
        logic mains_presence_gate_enable;
        logic long_alarm_wake_flag;
        logic short_alarm_wake_flag;
        logic [SWC_W-1:0] short_alarm_reload_value;
        logic [SWC_W-1:0] short_count;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic wake;
        logic subsec;
        logic irq;
    } wts_state_s;

    wts_state_s st_reg;
    wts_state_s st_next;

    wts_tick_if tk ();

    // ==========================================================
    // Checks
    // ==========================================================
    if (SRC_COUNT < 1 || SRC_COUNT > (1 << SRC_SEL_W) || SRC_SEL_W != SW_SRC_W) begin : g_bad
        $error("Clock source count does not fit the three-bit select field.");
    end

    // ==========================================================
    // Functions
    // ==========================================================
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    function automatic logic pick_src(input logic [SRC_COUNT-1:0] src,
                                      input logic [SRC_SEL_W-1:0] sel);
        logic r;
        r = 1'b0;
        for (int i = 0; i < SRC_COUNT; i++) begin
            if (sel == SRC_SEL_W'(i)) begin
                r = src[i];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Tick generator
    // ==========================================================
    assign tk.tick32 = st_reg.ref_sync & ~st_reg.ref_prev;
    assign tk.run = st_reg.long_alarm_run;
    assign tk.rate = st_reg.subsecond_rate_select;

    wts_subsec #(
        .DIV_BITS(DIV_W)
    ) u_subsec (
        .mclk(mclk),
        .rst(rst),
        .tk(tk)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    logic wr_ctl;
    logic wr_rate;
    logic wr_sw;
    logic wr_swc;
    logic wr_mask;
    logic rd_stat;
    logic short_tick;
    logic short_expire;
    logic long_set;
    logic short_set;
    logic long_part;
    logic wake_raw;
    logic [IRQ_W-1:0] irq_set;
    logic [SWC_W-1:0] load_val;

    always_comb begin
        st_next = st_reg;
        wr_ctl = reg_wr && addr_is(reg_addr, OFF_CONTROL);
        wr_rate = reg_wr && addr_is(reg_addr, OFF_RATE_SELECT);
        wr_sw = reg_wr && addr_is(reg_addr, OFF_SUBWEEK_CTRL);
        wr_swc = reg_wr && addr_is(reg_addr, OFF_SUBWEEK_COUNT);
        wr_mask = reg_wr && addr_is(reg_addr, OFF_IRQ_MASK);
        rd_stat = reg_rd && addr_is(reg_addr, OFF_IRQ_STATUS);
        load_val = reg_wdata[SWC_LOAD_LSB +: SWC_W];

        // Synchronisers; the second stage feeds logic, and the third reference stage gives the edge.
        st_next.ref_meta = ref_32k_pin;
        st_next.ref_sync = st_reg.ref_meta;
        st_next.ref_prev = st_reg.ref_sync;
        st_next.pres_meta = mains_presence_input;
        st_next.pres_sync = st_reg.pres_meta;

        // Software writes.
        if (wr_ctl) begin
            st_next.long_alarm_run = reg_wdata[CTL_RUN_BIT];
            st_next.wake_output_enable = reg_wdata[CTL_WAKE_EN_BIT];
        end
        if (wr_rate) begin
            st_next.subsecond_rate_select = reg_wdata[RATE_LSB +: RATE_W];
        end
        if (wr_sw) begin
            st_next.short_alarm_clock_select = reg_wdata[SW_SRC_LSB +: SRC_SEL_W];
            st_next.no_reload = reg_wdata[SW_NO_RELOAD_BIT];
            st_next.mains_presence_gate_enable = reg_wdata[SW_GATE_BIT];
        end
        if (wr_mask) begin
            st_next.irq_mask = reg_wdata[IRQ_W-1:0];
        end

        // Sub-week counter.
        // selected source clocks the counter.
        short_tick = pick_src(short_alarm_clock_select_src, st_reg.short_alarm_clock_select);
        short_expire = 1'b0;
        if (wr_swc) begin
            // nonzero write loads, zero write stops.
            st_next.short_alarm_reload_value = load_val;
            st_next.short_count = load_val;
        end else if (short_tick && st_reg.short_count != '0) begin
            if (st_reg.short_count == SWC_W'(1)) begin
                short_expire = 1'b1;
                if (!st_reg.no_reload) begin
                    st_next.short_count = st_reg.short_alarm_reload_value;
                end else begin
                    st_next.short_count = '0;
                end
            end else begin
                st_next.short_count = st_reg.short_count - SWC_W'(1);
            end
        end

        // Wake flags; a set in the clearing cycle wins.
        // long alarm flag set.
        long_set = week_compare_hit && st_reg.wake_output_enable;
        // short alarm flag set on expiry, when the counter steps from one.
        short_set = short_expire && st_reg.wake_output_enable;
        if (wr_sw && reg_wdata[SW_FLAG_LONG_BIT]) begin
            st_next.long_alarm_wake_flag = 1'b0;
        end
        if (wr_sw && reg_wdata[SW_FLAG_SHORT_BIT]) begin
            st_next.short_alarm_wake_flag = 1'b0;
        end
        if (long_set) begin
            st_next.long_alarm_wake_flag = 1'b1;
        end
        if (short_set) begin
            st_next.short_alarm_wake_flag = 1'b1;
        end

        // Wake output.
        // long part follows the live compare level.
        long_part = week_compare_hit;
        // short part persists on its flag.
        wake_raw = long_part || st_reg.short_alarm_wake_flag;
        if (st_reg.mains_presence_gate_enable && !st_reg.pres_sync) begin
            wake_raw = 1'b0;
        end
        // enable bit clear holds the output low.
        st_next.wake = wake_raw && st_reg.wake_output_enable;

        // Event interrupt; a read clears, but a new event in that cycle stays.
        st_next.subsec = tk.evt;
        irq_set = '0;
        irq_set[IRQ_SUBSEC_BIT] = tk.evt;
        irq_set[IRQ_SHORT_BIT] = short_expire;
        irq_set[IRQ_LONG_BIT] = week_compare_hit && !st_reg.long_alarm_wake_flag
                                && st_reg.wake_output_enable;
        if (rd_stat) begin
            st_next.irq_status = irq_set;
        end else begin
            st_next.irq_status = st_reg.irq_status | irq_set;
        end
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        // Read data, valid only in the cycle after the strobe.
        st_next.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFF_CONTROL: begin
                    st_next.rdata[CTL_RUN_BIT] = st_reg.long_alarm_run;
                    st_next.rdata[CTL_WAKE_EN_BIT] = st_reg.wake_output_enable;
                end
                OFF_RATE_SELECT: begin
                    st_next.rdata[RATE_LSB +: RATE_W] = st_reg.subsecond_rate_select;
                end
                OFF_SUBWEEK_CTRL: begin
                    st_next.rdata[SW_SRC_LSB +: SRC_SEL_W] = st_reg.short_alarm_clock_select;
                    st_next.rdata[SW_NO_RELOAD_BIT] = st_reg.no_reload;
                    st_next.rdata[SW_GATE_BIT] = st_reg.mains_presence_gate_enable;
                    st_next.rdata[SW_MAINS_LEVEL_BIT] = st_reg.pres_sync;
                    st_next.rdata[SW_FLAG_LONG_BIT] = st_reg.long_alarm_wake_flag;
                    st_next.rdata[SW_FLAG_SHORT_BIT] = st_reg.short_alarm_wake_flag;
                end
                OFF_SUBWEEK_COUNT: begin
                    st_next.rdata[SWC_LOAD_LSB +: SWC_W] = st_reg.short_alarm_reload_value;
                    st_next.rdata[SWC_STATUS_LSB +: SWC_W] = st_reg.short_count;
                end
                OFF_IRQ_STATUS: begin
                    st_next.rdata[IRQ_W-1:0] = st_reg.irq_status;
                end
                OFF_IRQ_MASK: begin
                    st_next.rdata[IRQ_W-1:0] = st_reg.irq_mask;
                end
                default: begin
                    st_next.rdata = '0;
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.long_alarm_run <= RST_RUN;
            st_reg.wake_output_enable <= RST_WAKE_EN;
            st_reg.subsecond_rate_select <= RST_RATE;
            st_reg.short_alarm_clock_select <= RST_SRC;
            st_reg.short_alarm_reload_value <= RST_SWC;
            st_reg.short_count <= RST_SWC;
            st_reg.irq_status <= RST_IRQ;
            st_reg.irq_mask <= RST_IRQ;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign wake_event = st_reg.wake;
    assign subsecond_event = st_reg.subsec;
    assign irq = st_reg.irq;

endmodule

// ===== test/wts_ctrl_chk.sv
// Port checker for the week timer sub-second and sub-week control block.
// Assumes it is bound to wts_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module wts_ctrl_chk #(
    parameter int SRC_COUNT = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [wts_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic ref_32k_pin,
    input wire logic mains_presence_input,
    input wire logic week_compare_hit,
    input wire logic [SRC_COUNT-1:0] short_alarm_clock_select_src,
    input wire logic wake_event,
    input wire logic subsecond_event,
    input wire logic irq
);
    import wts_pkg::*;
    // ==========================================================
    // Shadow registers
    // ==========================================================
    // Shadows mirror what software wrote, so outputs can be tied to settings.
    logic wen_q, gate_q, pin_d, mains_d, w1c_short;
    logic [3:0] rate_q, rise_cnt;
    logic [2:0] mask_q, mains_cnt;
    logic [8:0] reload_q;
    assign w1c_short = reg_wr && reg_addr == OFF_SUBWEEK_CTRL && reg_wdata[SW_FLAG_SHORT_BIT];
    always_ff @(posedge mclk) begin
        pin_d <= ref_32k_pin;
        mains_d <= mains_presence_input;
        if (rst) begin
            wen_q <= 1'b0;
            gate_q <= 1'b0;
            rate_q <= 4'h0;
            mask_q <= 3'h0;
            reload_q <= 9'h000;
            rise_cnt <= 4'hF;
            mains_cnt <= 3'h0;
        end else begin
            rise_cnt <= (ref_32k_pin && !pin_d) ? 4'h0 : rise_cnt + {3'h0, rise_cnt != 4'hF};
            mains_cnt <= (mains_presence_input != mains_d) ? 3'h0 :
                mains_cnt + {2'h0, mains_cnt != 3'h7};
            if (reg_wr && reg_addr == OFF_CONTROL) wen_q <= reg_wdata[CTL_WAKE_EN_BIT];
            if (reg_wr && reg_addr == OFF_SUBWEEK_CTRL) gate_q <= reg_wdata[SW_GATE_BIT];
            if (reg_wr && reg_addr == OFF_RATE_SELECT) rate_q <= reg_wdata[3:0];
            if (reg_wr && reg_addr == OFF_IRQ_MASK) mask_q <= reg_wdata[2:0];
            if (reg_wr && reg_addr == OFF_SUBWEEK_COUNT) reload_q <= reg_wdata[8:0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Assertions
    // ==========================================================
    AST_RATE_READ: assert property (
        reg_rd && reg_addr == OFF_RATE_SELECT |=> reg_rdata == {28'h0, $past(rate_q)})
        else $error("Rate select read back wrong.");
    AST_RATE_OFF: assert property (
        rate_q == 4'h0 && $past(rate_q) == 4'h0 && $past(rate_q, 2) == 4'h0
        && $past(rate_q, 3) == 4'h0 |-> !subsecond_event)
        else $error("Sub-second event while rate is zero.");
    AST_SUBSEC_PULSE: assert property (
        subsecond_event |=> !subsecond_event) else $error("Sub-second event longer than a cycle.");
    AST_SUBSEC_CAUSE: assert property (
        subsecond_event |-> rise_cnt >= 4'h2 && rise_cnt <= 4'h9)
        else $error("Sub-second event without a reference edge.");
    AST_WAKE_OFF: assert property (
        !wen_q |=> !wake_event) else $error("Wake output high while disabled.");
    AST_GATE: assert property (
        gate_q && !mains_presence_input && $stable(mains_presence_input)
        && mains_cnt >= 3'h3 |=> !wake_event) else $error("Wake output high without mains.");
    AST_LONG_WAKE: assert property (
        wen_q && !gate_q && week_compare_hit |=> wake_event)
        else $error("Week compare hit did not raise the wake output.");
    AST_SHORT_HOLD: assert property (
        wake_event && wen_q && !gate_q && !$past(week_compare_hit) && !$past(w1c_short)
        |=> wake_event) else $error("Sub-week wake dropped before its flag was cleared.");
    AST_MAINS_READ: assert property (
        reg_rd && reg_addr == OFF_SUBWEEK_CTRL && $stable(mains_presence_input) && mains_cnt >= 3'h4
        |=> reg_rdata[SW_MAINS_LEVEL_BIT] == $past(mains_presence_input))
        else $error("Mains level bit does not follow the pin.");
    AST_RELOAD_READ: assert property (
        reg_rd && reg_addr == OFF_SUBWEEK_COUNT |=> reg_rdata[8:0] == $past(reload_q)
        && reg_rdata[24:16] <= $past(reload_q) && reg_rdata[31:25] == 7'h0 && reg_rdata[15:9] == 7'h0)
        else $error("Sub-week counter read back wrong.");
    AST_IRQ_MASKED: assert property (
        mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq) else $error("Interrupt high while masked.");
    COV_SUBSEC: cover property (subsecond_event);
    COV_SHORT_WAKE: cover property (wake_event && !week_compare_hit);
    COV_IRQ: cover property (irq);
    COV_GATED: cover property (gate_q && week_compare_hit && !wake_event);
endmodule
bind wts_ctrl wts_ctrl_chk #(.SRC_COUNT(SRC_COUNT)) u_chk (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_32k_pin(ref_32k_pin),
    .mains_presence_input(mains_presence_input), .week_compare_hit(week_compare_hit),
    .short_alarm_clock_select_src(short_alarm_clock_select_src), .wake_event(wake_event),
    .subsecond_event(subsecond_event), .irq(irq));

// ===== test/testbench.sv
// Self-checking bench of the week timer control block: registers, rates,
// sub-week counter, wake output and interrupt.
// Assumes the block is the only device on its register port.
`timescale 1ns/1ps
module testbench;
    import wts_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ref_32k_pin = 1'b0;
    logic mains = 1'b0;
    logic hit = 1'b0;
    logic [7:0] src = 8'h00;
    logic [31:0] reg_rdata, d;
    logic wake_event, subsecond_event, irq;
    logic [3:0] rt;
    logic [3:0] rates[5] = '{4'hF, 4'hD, 4'hB, 4'h0, 4'h0};
    logic [7:0] radr[6] = '{OFF_CONTROL, OFF_RATE_SELECT, OFF_SUBWEEK_CTRL, OFF_SUBWEEK_COUNT,
        OFF_IRQ_MASK, 8'h3C};
    logic [31:0] rrst[6] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    int n_mismatch = 0;
    int compares = 0;
    int n_evt = 0;
    int n0, k, s, o, r;
    always #2 mclk = ~mclk;
    wts_ctrl u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_32k_pin(ref_32k_pin),
        .mains_presence_input(mains), .week_compare_hit(hit), .short_alarm_clock_select_src(src),
        .wake_event(wake_event), .subsecond_event(subsecond_event), .irq(irq));
    always @(posedge mclk) begin
        if (subsecond_event === 1'b1) n_evt++;
    end
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic wrap_up();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge mclk);
            ref_32k_pin <= 1'b1;
            cyc(4);
            ref_32k_pin <= 1'b0;
            cyc(3);
        end
    endtask
    task automatic swt(input int i);
        @(posedge mclk);
        src <= 8'h01 << i;
        @(posedge mclk);
        src <= 8'h00;
        cyc(2);
    endtask
    // Bounded wait; a wake output stuck at the wrong level ends the run.
    task automatic wait_wake(input logic exp);
        int i;
        for (i = 0; i < 12 && wake_event !== exp; i++) @(posedge mclk);
        chk({31'h0, wake_event}, {31'h0, exp});
        if (wake_event !== exp) wrap_up();
    endtask
    function automatic int exp_evt(input logic [3:0] n, input int t);
        return (n == 4'h0) ? 0 : t >> (15 - n);
    endfunction
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(19376));
        cyc(3);
        rst <= 1'b0;
        foreach (radr[j]) rchk(radr[j], rrst[j]);
        repeat (6) begin
            d = $urandom;
            wr(OFF_RATE_SELECT, d);
            rchk(OFF_RATE_SELECT, d & 32'hF);
        end
        rates[4] = 4'hB + 4'($urandom % 5);
        foreach (rates[j]) begin
            rt = rates[j];
            wr(OFF_RATE_SELECT, {28'h0, rt});
            wr(OFF_CONTROL, 32'h0);
            wr(OFF_CONTROL, 32'h1);
            n0 = n_evt;
            k = (rt == 4'h0) ? 32 : 4 << (15 - rt);
            ticks(k);
            cyc(8);
            chk(n_evt - n0, exp_evt(rt, k));
        end
        rchk(OFF_IRQ_STATUS, 32'h1);
        wr(OFF_IRQ_MASK, 32'h1);
        wr(OFF_RATE_SELECT, 32'hF);
        ticks(1);
        wr(OFF_RATE_SELECT, 32'h0);
        cyc(6);
        chk({31'h0, irq}, 32'h1);
        rchk(OFF_IRQ_STATUS, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_MASK, 32'h0);
        wr(OFF_RATE_SELECT, 32'hF);
        ticks(1);
        wr(OFF_RATE_SELECT, 32'h0);
        cyc(6);
        chk({31'h0, irq}, 32'h0);
        rchk(OFF_IRQ_STATUS, 32'h1);
        s = $urandom % 8;
        o = (s + 1 + $urandom % 7) % 8;
        r = 2 + $urandom % 8;
        wr(OFF_CONTROL, 32'h41);
        wr(OFF_SUBWEEK_CTRL, s << 7);
        wr(OFF_SUBWEEK_COUNT, r);
        swt(o);
        rchk(OFF_SUBWEEK_COUNT, r << 16 | r);
        repeat (r - 1) swt(s);
        rchk(OFF_SUBWEEK_COUNT, 32'h0001_0000 | r);
        swt(s);
        rchk(OFF_SUBWEEK_COUNT, r << 16 | r);
        rchk(OFF_SUBWEEK_CTRL, s << 7 | 1);
        cyc(20);
        wait_wake(1'b1);
        rchk(OFF_IRQ_STATUS, 32'h2);
        wr(OFF_SUBWEEK_CTRL, s << 7);
        cyc(4);
        wait_wake(1'b1);
        wr(OFF_SUBWEEK_CTRL, s << 7 | 1);
        cyc(3);
        wait_wake(1'b0);
        wr(OFF_SUBWEEK_CTRL, s << 7 | 32'h40);
        repeat (r) swt(s);
        rchk(OFF_SUBWEEK_COUNT, r);
        wait_wake(1'b1);
        wr(OFF_SUBWEEK_CTRL, s << 7 | 32'h41);
        wr(OFF_SUBWEEK_COUNT, 32'h5);
        swt(s);
        rchk(OFF_SUBWEEK_COUNT, 32'h0004_0005);
        wr(OFF_SUBWEEK_COUNT, 32'h0);
        swt(s);
        rchk(OFF_SUBWEEK_COUNT, 32'h0);
        wr(OFF_SUBWEEK_CTRL, 32'h0);
        hit <= 1'b1;
        wait_wake(1'b1);
        hit <= 1'b0;
        cyc(3);
        wait_wake(1'b0);
        rchk(OFF_SUBWEEK_CTRL, 32'h2);
        rchk(OFF_IRQ_STATUS, 32'h6);
        wr(OFF_SUBWEEK_CTRL, 32'h2);
        rchk(OFF_SUBWEEK_CTRL, 32'h0);
        wr(OFF_SUBWEEK_CTRL, 32'h20);
        hit <= 1'b1;
        cyc(6);
        wait_wake(1'b0);
        mains <= 1'b1;
        wait_wake(1'b1);
        rchk(OFF_SUBWEEK_CTRL, 32'h32);
        wr(OFF_SUBWEEK_CTRL, 32'h0);
        mains <= 1'b0;
        cyc(6);
        wait_wake(1'b1);
        rchk(OFF_SUBWEEK_CTRL, 32'h2);
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_SUBWEEK_CTRL, 32'h2);
        cyc(3);
        wait_wake(1'b0);
        hit <= 1'b0;
        rchk(OFF_SUBWEEK_CTRL, 32'h0);
        wr(OFF_CONTROL, 32'h41);
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        rchk(OFF_CONTROL, 32'h1);
        wrap_up();
    end
endmodule
